// file: fpm_map.svh
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH
// ---------------------------------------------------------------------------
// register map (wishbone byte addresses)
// ---------------------------------------------------------------------------
`define FPM_ADR_CTRL     8'h00
`define FPM_ADR_LEVEL    8'h04
`define FPM_ADR_STAT     8'h08
`define FPM_ADR_VER      8'h0c
`define FPM_ADR_SET      8'h10
`define FPM_CTRL_MUTE    0
`define FPM_LEVEL_RST    8'hec
`define FPM_MUTE_RST     1'b0
// ---------------------------------------------------------------------------
// setting limits and reset values (bcd, output level limits signed binary)
// ---------------------------------------------------------------------------
`define FPM_FREQ_MIN     20'h20000
`define FPM_FREQ_MAX     20'h25000
`define FPM_FREQ_RST     20'h22500
`define FPM_GAIN_MAX     8'h50
`define FPM_GAIN_RST     8'h00
`define FPM_OUT_MAX      10'sd0
`define FPM_OUT_MIN      -10'sd20
// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define FPM_CLK_NS       10
`define FPM_TICK_NS      1000000
`define FPM_TIMEOUT_MS   12000
`define FPM_LAMP_MS      1000
`define FPM_VER_MS       1000
`define FPM_MUTE_MS      50
`endif

// file: fpm_pkg.sv
package fpm_pkg;
  // ui states, one-hot
  typedef enum logic [5:0] {
    S_TEST = 6'h01,
    S_VER  = 6'h02,
    S_NORM = 6'h04,
    S_EDIT = 6'h08,
    S_ASK  = 6'h10,
    S_DONE = 6'h20
  } fpm_state_t;
  // menu order as presented to the operator
  typedef enum logic [2:0] {
    M_FREQ = 3'h0,
    M_GAIN = 3'h1,
    M_REM  = 3'h2,
    M_INV  = 3'h3,
    M_REF  = 3'h4,
    M_ROUT = 3'h5,
    M_IF   = 3'h6,
    M_ADDR = 3'h7
  } fpm_menu_t;
  // all settings, digits in bcd, most significant first
  typedef struct packed {
    logic [4:0][3:0] freq;
    logic [1:0][3:0] gain;
    logic            remote;
    logic            invert;
    logic            ext_ref;
    logic            ref_out;
    logic [1:0]      iface;
    logic [1:0][3:0] addr;
  } fpm_set_t;
  // panel switch levels, high while pressed
  typedef struct packed {
    logic sel;
    logic left;
    logic right;
    logic up;
    logic down;
  } fpm_sw_t;
  // what the lcd driver shows
  typedef struct packed {
    fpm_state_t  state;
    fpm_menu_t   menu;
    logic [2:0]  cursor;
    logic        yes;
    fpm_set_t    shown;
  } fpm_disp_t;
endpackage

// file: fpm_top.sv
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "fpm_map.svh"
module fpm_top
  import fpm_pkg::*;
#(
  parameter int          TICK_CYC     = `FPM_TICK_NS / `FPM_CLK_NS,
  parameter int          TIMEOUT_TICK = `FPM_TIMEOUT_MS * (1000000 / `FPM_TICK_NS),
  parameter logic [15:0] VERSION      = 16'h0102  // arbitrary value
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // front panel
  input  wire fpm_sw_t     sw_in,
  input  wire logic        pll_lock_in,
  output fpm_disp_t        disp_out,
  output logic             alarm_led_out,
  output logic             remote_led_out,
  output logic             mute_led_out,
  // nonvolatile storage
  input  wire fpm_set_t    nvm_rd_data_in,
  output logic             nvm_wr_out,
  output fpm_set_t         nvm_wr_data_out,
  // rf control
  output logic      [19:0] freq_out,
  output logic      [7:0]  gain_out,
  output fpm_set_t         applied_out,
  output logic             carrier_mute_out
);

  // ---------------------------------------------------------------------------
  // constants and helpers
  // ---------------------------------------------------------------------------
  // divide first, as for the timeout, whose raw millisecond product would not fit in 32 bits
  localparam int LAMP_TICK = `FPM_LAMP_MS * (1000000 / `FPM_TICK_NS);
  localparam int VER_TICK  = `FPM_VER_MS * (1000000 / `FPM_TICK_NS);
  localparam int MUTE_TICK = `FPM_MUTE_MS * (1000000 / `FPM_TICK_NS);

  // one bcd digit up or down with wrap
  function automatic logic [3:0] fpm_step(input logic [3:0] d, input logic up);
    if (up) begin
      fpm_step = (d >= 4'h9) ? 4'h0 : d + 4'h1;
    end else begin
      fpm_step = (d == 4'h0) ? 4'h9 : d - 4'h1;
    end
  endfunction

  // editable places per menu; the place after the last is the save marker
  function automatic logic [2:0] fpm_ndig(input fpm_menu_t m);
    unique case (m)
      M_FREQ:  fpm_ndig = 3'd5;
      M_GAIN:  fpm_ndig = 3'd2;
      M_ADDR:  fpm_ndig = 3'd2;
      default: fpm_ndig = 3'd1;
    endcase
  endfunction

  // two bcd digits to a signed level term
  function automatic logic signed [9:0] fpm_bcd2bin(input logic [1:0][3:0] b);
    fpm_bcd2bin = 10'(b[1]) * 10'd10 + 10'(b[0]);
  endfunction

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  fpm_state_t   st_r;
  fpm_state_t   st_nxt;
  fpm_menu_t    menu_r;
  fpm_menu_t    menu_nxt;
  logic [2:0]   cur_r;
  logic [2:0]   cur_nxt;
  logic         yes_r;
  logic         yes_nxt;
  fpm_set_t     com_r;
  fpm_set_t     com_nxt;
  fpm_set_t     pend_r;
  fpm_set_t     pend_nxt;
  fpm_set_t     edit_set_w;
  logic         edit_ok_w;
  logic         wr_r;
  logic         wr_nxt;
  logic         loaded_r;
  fpm_sw_t      sw_prev_r;
  logic [31:0]  div_r;
  logic [31:0]  cnt_r;
  logic [31:0]  mute_cnt_r;
  logic [19:0]  freq_r;
  logic         cmute_r;
  logic         alarm_r;
  logic         mute_sel_r;
  logic [7:0]   lvl_r;
  logic         ack_r;
  logic [31:0]  dat_r;

  // ---------------------------------------------------------------------------
  // switch presses and timebase
  // ---------------------------------------------------------------------------
  // a press is the rising level; switches are not gated by remote mode
  wire fpm_sw_t press_w = sw_in & ~sw_prev_r;
  wire          sel_p   = press_w.sel;
  wire          left_p  = press_w.left;
  wire          right_p = press_w.right;
  wire          up_p    = press_w.up;
  wire          vert_p  = press_w.up | press_w.down;
  wire          any_p   = |press_w;
  wire          tick_w  = (div_r == 32'(TICK_CYC - 1));
  wire          idle_w  = (cnt_r >= 32'(TIMEOUT_TICK));
  wire          at_r_w  = (cur_r >= fpm_ndig(menu_r));
  wire          edit_w  = (st_r == S_EDIT) || (st_r == S_ASK);
  // output level the attenuator would give with the candidate gain
  wire logic signed [9:0] cand_lvl_w = $signed({{2{lvl_r[7]}}, lvl_r}) + fpm_bcd2bin(edit_set_w.gain);
  wire logic signed [9:0] out_lvl_w  = $signed({{2{lvl_r[7]}}, lvl_r}) + fpm_bcd2bin(pend_r.gain);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sw_prev_r <= '0;
      div_r     <= 32'h0;
    end else begin
      sw_prev_r <= sw_in;
      div_r     <= tick_w ? 32'h0 : div_r + 32'h1;
    end
  end

  // idle count restarts on any press and on each state change
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r <= 32'h0;
    end else if (any_p || st_nxt != st_r) begin
      cnt_r <= 32'h0;
    end else if (tick_w && cnt_r != 32'hffff_ffff) begin
      // saturates at the top only: boot delays can count past a short edit timeout
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // candidate value for a vertical press
  // ---------------------------------------------------------------------------
  always_comb begin
    edit_set_w = pend_r;
    edit_ok_w  = 1'b1;
    unique case (menu_r)
      M_FREQ: begin
        edit_set_w.freq[3'd4 - cur_r] = fpm_step(pend_r.freq[3'd4 - cur_r], up_p);
        edit_ok_w = (edit_set_w.freq >= `FPM_FREQ_MIN) && (edit_set_w.freq <= `FPM_FREQ_MAX);
      end
      M_GAIN: begin
        // tens digit is 10 dB a step, units 1 dB
        edit_set_w.gain[~cur_r[0]] = fpm_step(pend_r.gain[~cur_r[0]], up_p);
        edit_ok_w = (edit_set_w.gain <= `FPM_GAIN_MAX) &&
                    (cand_lvl_w <= `FPM_OUT_MAX) && (cand_lvl_w >= `FPM_OUT_MIN);
      end
      M_ADDR: edit_set_w.addr[~cur_r[0]] = fpm_step(pend_r.addr[~cur_r[0]], up_p);
      // on/off items flip whichever way the switch went
      M_REM:  edit_set_w.remote  = ~pend_r.remote;
      M_INV:  edit_set_w.invert  = ~pend_r.invert;
      M_REF:  edit_set_w.ext_ref = ~pend_r.ext_ref;
      M_ROUT: edit_set_w.ref_out = ~pend_r.ref_out;
      M_IF:   edit_set_w.iface   = pend_r.iface + 2'd1;
    endcase
  end

  // ---------------------------------------------------------------------------
  // menu state machine
  // ---------------------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    menu_nxt = menu_r;
    cur_nxt  = cur_r;
    yes_nxt  = yes_r;
    pend_nxt = pend_r;
    com_nxt  = com_r;
    wr_nxt   = 1'b0;
    unique case (st_r)
      // lamp test, then version, then normal display
      S_TEST: if (tick_w && cnt_r >= 32'(LAMP_TICK - 1)) st_nxt = S_VER;
      S_VER:  if (tick_w && cnt_r >= 32'(VER_TICK - 1)) st_nxt = S_NORM;
      S_NORM: begin
        if (sel_p) begin
          st_nxt   = S_EDIT;
          menu_nxt = M_FREQ;
          cur_nxt  = 3'd0;
        end
      end
      S_EDIT: begin
        if (idle_w) begin
          st_nxt   = S_NORM;
          pend_nxt = com_r;
        end else if (sel_p) begin
          if (at_r_w || menu_r == M_ADDR) begin
            st_nxt  = S_ASK;
            yes_nxt = 1'b0;
          end else begin
            menu_nxt = fpm_menu_t'(menu_r + 3'd1);
            cur_nxt  = 3'd0;
          end
        end else if (left_p && cur_r != 3'd0) begin
          cur_nxt = cur_r - 3'd1;
        end else if (right_p && !at_r_w) begin
          cur_nxt = cur_r + 3'd1;
        end else if (vert_p && !at_r_w && edit_ok_w) begin
          pend_nxt = edit_set_w;
        end
      end
      S_ASK: begin
        if (idle_w) begin
          st_nxt   = S_NORM;
          pend_nxt = com_r;
        end else if (sel_p) begin
          st_nxt = S_DONE;
          if (yes_r) begin
            com_nxt = pend_r;
            wr_nxt  = 1'b1;
          end else begin
            pend_nxt = com_r;
          end
        end else if (vert_p) begin
          yes_nxt = ~yes_r;
        end
      end
      S_DONE: if (sel_p) st_nxt = S_NORM;
    endcase
  end

  // settings are loaded from storage in the first cycle after reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r     <= S_TEST;
      menu_r   <= M_FREQ;
      cur_r    <= 3'd0;
      yes_r    <= 1'b0;
      wr_r     <= 1'b0;
      loaded_r <= 1'b0;
      com_r    <= '{freq: `FPM_FREQ_RST, gain: `FPM_GAIN_RST, default: '0};
      pend_r   <= '{freq: `FPM_FREQ_RST, gain: `FPM_GAIN_RST, default: '0};
    end else begin
      st_r     <= st_nxt;
      menu_r   <= menu_nxt;
      cur_r    <= cur_nxt;
      yes_r    <= yes_nxt;
      wr_r     <= wr_nxt;
      loaded_r <= 1'b1;
      com_r    <= loaded_r ? com_nxt : nvm_rd_data_in;
      pend_r   <= loaded_r ? pend_nxt : nvm_rd_data_in;
    end
  end

  // ---------------------------------------------------------------------------
  // rf side, carrier mute and indicators
  // ---------------------------------------------------------------------------
  // the mute holds for a while so the synthesizer can settle unseen
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      freq_r     <= `FPM_FREQ_RST;
      mute_cnt_r <= 32'h0;
      cmute_r    <= 1'b1;
      alarm_r    <= 1'b0;
    end else begin
      freq_r  <= com_r.freq;
      alarm_r <= !pll_lock_in;
      cmute_r <= mute_sel_r || (com_r.freq != freq_r) || (mute_cnt_r != 32'h0);
      if (com_r.freq != freq_r) begin
        mute_cnt_r <= 32'(MUTE_TICK);
      end else if (tick_w && mute_cnt_r != 32'h0) begin
        mute_cnt_r <= mute_cnt_r - 32'h1;
      end
    end
  end

  // gain follows the edit copy, which equals the committed copy outside edits
  assign gain_out         = pend_r.gain;
  assign freq_out         = freq_r;
  assign applied_out      = com_r;
  assign carrier_mute_out = cmute_r;
  assign alarm_led_out    = alarm_r;
  assign remote_led_out   = com_r.remote;
  assign mute_led_out     = mute_sel_r;
  assign nvm_wr_out       = wr_r;
  assign nvm_wr_data_out  = com_r;
  assign disp_out         = '{state: st_r, menu: menu_r, cursor: cur_r, yes: yes_r, shown: pend_r};

  // ---------------------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------------------
  // one wait state; unmapped addresses ack with zero and ignore writes
  wire        wb_hit_w = wb_cyc_in && wb_stb_in && !ack_r;
  wire        wb_wr_w  = wb_hit_w && wb_we_in && wb_sel_in[0];
  wire [31:0] stat_w   = {16'h0, pll_lock_in, st_r, menu_r, cur_r, yes_r, wr_r, 1'b0};
  wire [31:0] rd_w     = (wb_adr_in == `FPM_ADR_CTRL)  ? {31'h0, mute_sel_r} :
                         (wb_adr_in == `FPM_ADR_LEVEL) ? {24'h0, lvl_r} :
                         (wb_adr_in == `FPM_ADR_STAT)  ? stat_w :
                         (wb_adr_in == `FPM_ADR_VER)   ? {16'h0, VERSION} :
                         (wb_adr_in == `FPM_ADR_SET)   ? {4'h0, com_r.gain, com_r.freq} : 32'h0;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_r      <= 1'b0;
      dat_r      <= 32'h0;
      mute_sel_r <= `FPM_MUTE_RST;
      lvl_r      <= `FPM_LEVEL_RST;
    end else begin
      ack_r <= wb_hit_w;
      if (wb_hit_w) dat_r <= rd_w;
      if (wb_wr_w && wb_adr_in == `FPM_ADR_CTRL) mute_sel_r <= wb_dat_in[`FPM_CTRL_MUTE];
      if (wb_wr_w && wb_adr_in == `FPM_ADR_LEVEL) lvl_r <= wb_dat_in[7:0];
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = dat_r;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence seq_ask_yes;
    st_r == S_ASK && !idle_w && sel_p && yes_r;
  endsequence
  sequence seq_stored;
    nvm_wr_out && st_r == S_DONE && com_r == $past(pend_r);
  endsequence
  sequence seq_ask_no;
    st_r == S_ASK && !idle_w && sel_p && !yes_r;
  endsequence

  chk_alarm_follow: assert property (1'b1 |=> alarm_led_out == !$past(pll_lock_in))
    else $error("alarm does not follow lock");
  chk_freq_held: assert property (edit_w |=> $stable(freq_out))
    else $error("frequency moved during edit");
  chk_gain_range: assert property ((st_r == S_EDIT && $changed(gain_out)) |-> gain_out <= 8'h50)
    else $error("gain above range");
  chk_gain_window: assert property ((st_r == S_EDIT && $changed(gain_out)) |-> $past(cand_lvl_w) <= 10'sd0
                                    && $past(cand_lvl_w) >= -10'sd20)
    else $error("gain gives output outside window");
  chk_gain_live: assert property ((st_r == S_EDIT && menu_r == M_GAIN && vert_p && !idle_w && !sel_p && !left_p
                                   && !right_p && !at_r_w && edit_ok_w) |=> gain_out == $past(edit_set_w.gain))
    else $error("gain not applied at once");
  chk_mute_apply: assert property ($changed(freq_out) |-> carrier_mute_out ##1 carrier_mute_out)
    else $error("carrier not muted on new frequency");
  chk_idle_abort: assert property ((st_r == S_EDIT && idle_w) |=> st_r == S_NORM && pend_r == com_r)
    else $error("edit not abandoned on timeout");
  chk_last_menu: assert property ((st_r == S_EDIT && !idle_w && sel_p && menu_r == M_ADDR) |=> st_r == S_ASK)
    else $error("no save prompt after last menu");
  chk_cursor_move: assert property ((st_r == S_EDIT && !idle_w && !sel_p && right_p && !at_r_w)
                                    |=> cur_r == $past(cur_r) + 3'd1)
    else $error("cursor did not step right");
  chk_toggle_rem: assert property ((st_r == S_EDIT && menu_r == M_REM && !idle_w && !sel_p && !left_p && !right_p
                                    && vert_p && !at_r_w) |=> pend_r.remote != $past(pend_r.remote))
    else $error("remote setting did not toggle");
  chk_commit_yes: assert property (seq_ask_yes |=> seq_stored)
    else $error("yes did not store settings");
  chk_commit_no: assert property (seq_ask_no |=> st_r == S_DONE && pend_r == com_r && !nvm_wr_out)
    else $error("no did not restore settings");
  chk_boot_order: assert property ((st_r == S_VER && $past(st_r) != S_VER) |-> $past(st_r) == S_TEST)
    else $error("version shown out of order");
  chk_cursor_back: assert property ((st_r == S_EDIT && !idle_w && !sel_p && left_p && cur_r != 3'd0)
                                    |=> cur_r == $past(cur_r) - 3'd1)
    else $error("cursor did not step left");
  // the save prompt must give up on silence just like the menus do
  chk_ask_abort: assert property ((st_r == S_ASK && idle_w) |=> st_r == S_NORM && pend_r == com_r)
    else $error("save prompt not abandoned on timeout");
  chk_store_done: assert property (nvm_wr_out |-> st_r == S_DONE)
    else $error("storage written outside a commit");

endmodule

// file: fpm_nvm_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// nonvolatile storage seen from the panel controller
// ---------------------------------------------------------------------------
module fpm_nvm_model
  import fpm_pkg::*;
#(
  parameter fpm_set_t INIT = '0
) (
  // clock
  input  wire logic     clk_in,
  // write side
  input  wire logic     wr_in,
  input  wire fpm_set_t wr_data_in,
  // read side
  output fpm_set_t      rd_data_out
);
  // contents survive reset of the controller, only a write pulse changes them
  fpm_set_t store_r = INIT;
  always @(posedge clk_in) begin
    if (wr_in === 1'b1) begin
      store_r <= wr_data_in;
    end
  end
  assign rd_data_out = store_r;
endmodule

// file: tb_fpm_top.sv
`timescale 1ns/100ps
module tb_fpm_top;
  import fpm_pkg::*;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  localparam fpm_set_t NV0 = '{freq: 20'h21000, gain: 8'h05, default: '0};
  localparam logic [4:0] SEL = 5'h10, LFT = 5'h08, RGT = 5'h04, UP = 5'h02, DN = 5'h01;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = '0, rdat, wb_dat_out;
  logic        wb_ack_out, alarm_led_out, remote_led_out, mute_led_out, nvm_wr_out, carrier_mute_out;
  logic        pll_lock = 1'b1;
  fpm_sw_t     sw = '0;
  fpm_disp_t   disp_out;
  fpm_set_t    nvm_rd, nvm_wr_data_out, applied_out;
  logic [19:0] freq_out;
  logic [7:0]  gain_out;
  int          errors = 0, total_checks = 0, cyc_cnt = 0;
  // short tick keeps boot at 8000 clocks, short timeout ends an idle edit after 80
  fpm_top #(.TICK_CYC(4), .TIMEOUT_TICK(20)) i_fpm_top (
    .clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .sw_in(sw), .pll_lock_in(pll_lock), .disp_out(disp_out), .alarm_led_out(alarm_led_out),
    .remote_led_out(remote_led_out), .mute_led_out(mute_led_out), .nvm_rd_data_in(nvm_rd),
    .nvm_wr_out(nvm_wr_out), .nvm_wr_data_out(nvm_wr_data_out), .freq_out(freq_out), .gain_out(gain_out),
    .applied_out(applied_out), .carrier_mute_out(carrier_mute_out));
  fpm_nvm_model #(.INIT(NV0)) i_fpm_nvm_model (
    .clk_in(clk_in), .wr_in(nvm_wr_out), .wr_data_in(nvm_wr_data_out), .rd_data_out(nvm_rd));
  initial forever #5 clk_in = ~clk_in;
  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a hang ends the run well past the expected 17000 clocks
  always @(posedge clk_in) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      errors++;
      complete_run();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  // press and release one switch, then let the response land
  task automatic press(input logic [4:0] m);
    @(posedge clk_in) sw <= m;
    @(posedge clk_in) sw <= '0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_state(input fpm_state_t s, input int lim);
    int n;
    n = 0;
    while (disp_out.state !== s && n < lim) begin
      @(posedge clk_in);
      n++;
    end
    #1;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in) {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    if (wb_ack_out !== 1'b1) errors++;
    rdat = wb_dat_out;
    {cyc, stb} <= 2'b00;
    @(posedge clk_in);
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_boot();
    check(disp_out.state, S_TEST);
    wait_state(S_VER, 5000);
    check(disp_out.state, S_VER);
    wait_state(S_NORM, 5000);
    check(disp_out.state, S_NORM);
    check({freq_out, gain_out}, {20'h21000, 8'h05});
  endtask
  // gain moves live, range refused, then no restores and yes stores
  task automatic t_gain();
    press(SEL); press(SEL);
    press(UP);
    check(gain_out, 8'h15);
    check(applied_out.gain, 8'h05);
    press(UP);
    check(gain_out, 8'h15);
    press(RGT); press(DN);
    check(gain_out, 8'h14);
    press(RGT); press(SEL);
    check(disp_out.state, S_ASK);
    press(SEL);
    check(gain_out, 8'h05);
    press(SEL);
    check(disp_out.state, S_NORM);
    press(SEL); press(SEL); press(RGT); press(UP); press(RGT); press(SEL); press(UP); press(SEL);
    check(nvm_rd.gain, 8'h06);
    press(SEL);
  endtask
  // frequency held back until yes, remote toggles both ways in its menu, past menu 8 asks
  task automatic t_freq();
    int i;
    press(SEL); press(RGT); press(UP);
    check(disp_out.shown.freq, 20'h22000);
    check(freq_out, 20'h21000);
    press(SEL); press(SEL);
    check(disp_out.menu, M_REM);
    press(UP); press(DN);
    check(disp_out.shown.remote, 1'b0);
    press(UP);
    for (i = 0; i < 6; i++) press(SEL);
    check(disp_out.state, S_ASK);
    press(UP); press(SEL);
    check({freq_out, carrier_mute_out, remote_led_out}, {20'h22000, 2'b11});
    check(nvm_rd.remote, 1'b1);
    press(SEL);
  endtask
  // idle edit in remote mode is dropped after the timeout
  task automatic t_timeout();
    press(SEL); press(RGT); press(RGT); press(LFT);
    check(disp_out.cursor, 3'h1);
    press(UP);
    check(disp_out.shown.freq, 20'h23000);
    wait_state(S_NORM, 200);
    check(disp_out.state, S_NORM);
    check(freq_out, 20'h22000);
  endtask
  task automatic t_misc();
    @(posedge clk_in) pll_lock <= 1'b0;
    repeat (3) @(posedge clk_in);
    check(alarm_led_out, 1'b1);
    pll_lock <= 1'b1;
    wb(1'b1, 8'h00, 32'h1);
    repeat (2) @(posedge clk_in);
    check(mute_led_out, 1'b1);
    wb(1'b0, 8'h10, 32'h0);
    check(rdat, {4'h0, 8'h06, 20'h22000});
    wb(1'b0, 8'h40, 32'h0);
    check(rdat, 32'h0);
    check(alarm_led_out, 1'b0);
  endtask
  // power cycle: committed settings come back from storage
  task automatic t_power();
    @(posedge clk_in) resetn_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    #1;
    check(disp_out.state, S_TEST);
    wait_state(S_NORM, 9000);
    check({freq_out, gain_out, remote_led_out}, {20'h22000, 8'h06, 1'b1});
  endtask
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    #1;
    t_boot();
    t_gain();
    t_freq();
    t_timeout();
    t_misc();
    t_power();
    complete_run();
  end
endmodule
